// *** rtc_alarm_regs.vh ***
/*
 * Register offsets, control bit positions and reset values of the
 * alarm and control block of the low-power real-time clock.
 * Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
 */
// Functional notes
// - Alarm fires only on exact 32-bit equality.
// - Auto-reset zeroes timer one cycle after alarm.
// - Alarm event routed to reset, wake or interrupt.
// - Writing zero to alarm enable clears flag.
// - Re-enable on an unchanged held match: alarm fires again at once.
// - Alarm flag lasts at most one cycle.
// - Without auto-reset the timer wraps and continues.
// - Control register at 0x04 holds eight bits.
// - Bit 7 enables the slow oscillator.
// - Bit 6 enables the missing-clock detector.
// - Bit 5 fail flag set on timeout, software clears.
// - Bit 4 runs or holds the timer.
// - Bit 3 permits or suppresses alarm events.
// - Running timer increments once per cycle.
// - Bit 2 reads flag, write sets auto-reset.
// - Set bit loads timer from capture, self-clears.
// - Capture bit snapshots timer, self-clears.
`ifndef RTC_ALARM_REGS_VH
`define RTC_ALARM_REGS_VH

// ********************************
// Register byte offsets
// ********************************
`define RTC_CONTROL_OFS     8'h04
`define RTC_ALARM_OFS       8'h08
`define RTC_SNAPSHOT_OFS    8'h0c
`define RTC_ROUTE_OFS       8'h10

// ********************************
// Control bit positions
// ********************************
`define CTL_OSC_ENABLE      7
`define CTL_MCLK_ENABLE     6
`define CTL_OSC_FAIL        5
`define CTL_TIMER_RUN       4
`define CTL_ALARM_ENABLE    3
`define CTL_ALARM_FLAG      2
`define CTL_SET_REQ         1
`define CTL_CAP_REQ         0

// ********************************
// Route bits and reset values
// ********************************
`define ROUTE_IRQ           0
`define ROUTE_WAKE          1
`define ROUTE_RESET         2
`define ROUTE_RESET_VAL     3'h0
`define ALARM_RESET_VAL     32'h00000000
`define AXI_OKAY            2'h0
`define AXI_SLVERR          2'h2

`endif

// *** rtc_alarm_timer_control.v ***
/*
 * Timer, alarm compare, auto-reset and control register of the real-time
 * clock, with an AXI4-Lite register slave.
 * Assumes aclk is the slow oscillator clock; missing-clock timeout arrives
 * as a synchronous pulse from the analog detector.
 */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rtc_alarm_regs.vh"

module rtc_alarm_timer_control #(
	parameter TIMER_WIDTH = 32
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        mclk_timeout,
	output reg         osc_enable,
	output reg         missing_clock_detect_enable,
	output reg         alarm_irq,
	output reg         alarm_wake,
	output reg         alarm_reset
);

	// ********************************
	// Behaviour summary
	// ********************************
	// Register map, byte addresses:
	//   0x04 control, eight bits
	//   0x08 alarm match value, full word
	//   0x0c timer snapshot value, full word
	//   0x10 event route bits, three bits
	// Control bits, read side:
	//   7 oscillator enable
	//   6 missing-clock detect enable
	//   5 oscillator fail flag
	//   4 timer run
	//   3 alarm enable
	//   2 alarm event flag
	//   1 set request, busy while high
	//   0 capture request, busy while high
	// Control bits, write side:
	//   bit 2 written selects auto-reset
	//   bit 5 written zero clears fail flag
	//   bits 1 and 0 written one start a request
	//   bits 1 and 0 written zero do nothing
	// Write timing:
	//   address and data taken in either order
	//   register updated on the edge after both held
	//   response valid from that same edge
	//   response held until the master takes it
	// Read timing:
	//   address taken while no response pending
	//   data and response valid one edge later
	//   held until the master takes them
	// Unmapped words:
	//   writes ignored, slave error response
	//   reads return zero, slave error response
	// Alarm timing:
	//   compare is combinational on the timer
	//   event flag registered, one cycle wide
	//   route outputs pulse with the flag
	//   a match that stays does not fire again
	// Auto-reset timing:
	//   timer shows zero in the flag cycle
	//   so the period is match value plus one
	// Timer counts only with oscillator and run set
	// Set request has priority over auto-reset
	// Auto-reset has priority over counting
	// Capture has priority over a snapshot write
	// Fail flag: hardware set beats software clear
	// Limitations:
	//   no oscillator trim or load settings here
	//   the route bits only steer the pulses
	//   the pulses are not latched in this block

	// ********************************
	// State
	// ********************************
	reg [TIMER_WIDTH-1:0] timer_q;
	reg [TIMER_WIDTH-1:0] alarm_match_value;
	reg [TIMER_WIDTH-1:0] timer_snapshot_value;
	reg                   timer_run;
	reg                   alarm_enable;
	reg                   auto_reset_q;
	reg                   alarm_flag_q;
	reg                   clear_pending_q;
	reg                   osc_fail_q;
	reg                   set_req_q;
	reg                   cap_req_q;
	reg [2:0]             route_q;
	reg                   aw_held_q;
	reg [7:0]             aw_addr_q;
	reg                   w_held_q;
	reg [31:0]            w_data_q;
	reg [3:0]             w_strb_q;

	wire do_write;
	wire match;
	wire alarm_event;
	wire tick;
	wire [7:0] ctl_read;

	// Byte-0 write to one decoded word
	function wr_hit;
		input [7:0] addr;
		input [7:0] ofs;
		input [3:0] strb;
		begin
			wr_hit = (addr[7:2] == ofs[7:2]) && strb[0];
		end
	endfunction

	// ********************************
	// AXI4-Lite write channel
	// ********************************
	// Address and data captured in either order; one write outstanding
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q    <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_held_q     <= 1'b0;
			w_data_q     <= 32'h00000000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_q[7:2])
					`RTC_CONTROL_OFS  >> 2,
					`RTC_ALARM_OFS    >> 2,
					`RTC_SNAPSHOT_OFS >> 2,
					`RTC_ROUTE_OFS    >> 2: s_axi_bresp <= `AXI_OKAY;
					default:                s_axi_bresp <= `AXI_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ********************************
	// AXI4-Lite read channel
	// ********************************
	// Control read: bit 2 shows the alarm flag, not auto-reset
	assign ctl_read = {osc_enable, missing_clock_detect_enable, osc_fail_q, timer_run,
		alarm_enable, alarm_flag_q, set_req_q, cap_req_q};
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `AXI_OKAY;
			case (s_axi_araddr[7:2])
				`RTC_CONTROL_OFS  >> 2: s_axi_rdata <= {24'h000000, ctl_read};
				`RTC_ALARM_OFS    >> 2: s_axi_rdata <= alarm_match_value;
				`RTC_SNAPSHOT_OFS >> 2: s_axi_rdata <= timer_snapshot_value;
				`RTC_ROUTE_OFS    >> 2: s_axi_rdata <= {29'h00000000, route_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ********************************
	// Control and configuration
	// ********************************
	// Exact 32-bit compare, gated by enable
	assign match = alarm_enable && (timer_q == alarm_match_value);
	// New entry into equality only; a held match does not fire again
	assign alarm_event = match && !clear_pending_q && !alarm_flag_q;
	assign tick  = osc_enable && timer_run; // Timer only counts with oscillator on

	always @(posedge aclk) begin
		if (!aresetn) begin
			osc_enable                  <= 1'b0;
			missing_clock_detect_enable <= 1'b0;
			timer_run                   <= 1'b0;
			alarm_enable                <= 1'b0;
			auto_reset_q                <= 1'b0;
			osc_fail_q                  <= 1'b0;
			alarm_match_value           <= `ALARM_RESET_VAL;
			route_q                     <= `ROUTE_RESET_VAL;
		end else begin
			if (do_write && wr_hit(aw_addr_q, `RTC_CONTROL_OFS, w_strb_q)) begin
				osc_enable                  <= w_data_q[`CTL_OSC_ENABLE];
				missing_clock_detect_enable <= w_data_q[`CTL_MCLK_ENABLE];
				timer_run                   <= w_data_q[`CTL_TIMER_RUN];
				alarm_enable                <= w_data_q[`CTL_ALARM_ENABLE];
				auto_reset_q                <= w_data_q[`CTL_ALARM_FLAG];
			end
			// Fail flag: set by timeout while detect enabled, else takes written bit; set wins
			if (missing_clock_detect_enable && mclk_timeout)
				osc_fail_q <= 1'b1;
			else if (do_write && wr_hit(aw_addr_q, `RTC_CONTROL_OFS, w_strb_q))
				osc_fail_q <= w_data_q[`CTL_OSC_FAIL];
			if (do_write && (aw_addr_q[7:2] == `RTC_ALARM_OFS >> 2)) begin
				alarm_match_value <= w_data_q;
			end
			if (do_write && wr_hit(aw_addr_q, `RTC_ROUTE_OFS, w_strb_q))
				route_q <= w_data_q[2:0];
		end
	end

	// ********************************
	// Timer, set and capture
	// ********************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			timer_q              <= {TIMER_WIDTH{1'b0}};
			timer_snapshot_value <= {TIMER_WIDTH{1'b0}};
			set_req_q            <= 1'b0;
			cap_req_q            <= 1'b0;
		end else begin
			if (set_req_q) begin
				timer_q   <= timer_snapshot_value;
				set_req_q <= 1'b0;
			end else if (auto_reset_q && alarm_event) begin
				timer_q <= {TIMER_WIDTH{1'b0}}; // Zero one cycle after the match cycle
			end else if (tick) begin
				timer_q <= timer_q + 1'b1; // Natural wrap, count continues
			end
			if (cap_req_q) begin
				timer_snapshot_value <= timer_q;
				cap_req_q            <= 1'b0;
			end else if (do_write && (aw_addr_q[7:2] == `RTC_SNAPSHOT_OFS >> 2)) begin
				timer_snapshot_value <= w_data_q;
			end
			if (do_write && wr_hit(aw_addr_q, `RTC_CONTROL_OFS, w_strb_q)) begin
				if (w_data_q[`CTL_SET_REQ])
					set_req_q <= 1'b1;
				if (w_data_q[`CTL_CAP_REQ])
					cap_req_q <= 1'b1;
			end
		end
	end

	// ********************************
	// Alarm flag and routing
	// ********************************
	// Flag pulses one cycle per match entry; a held match does not re-fire,
	// but a disabled alarm clears clear_pending_q, so a re-enable fires at once
	always @(posedge aclk) begin
		if (!aresetn) begin
			alarm_flag_q    <= 1'b0;
			clear_pending_q <= 1'b0;
			alarm_irq       <= 1'b0;
			alarm_wake      <= 1'b0;
			alarm_reset     <= 1'b0;
		end else begin
			clear_pending_q <= match;
			alarm_flag_q    <= alarm_event;
			alarm_irq       <= alarm_event && route_q[`ROUTE_IRQ];
			alarm_wake      <= alarm_event && route_q[`ROUTE_WAKE];
			alarm_reset     <= alarm_event && route_q[`ROUTE_RESET];
		end
	end

endmodule

// *** rtc_alarm_chk.sv ***
/*
 * Checker for the alarm and control block: bus handshakes, alarm pulses, reset.
 * Assumes it is bound to the block's top module and sees only its ports.
 */
`timescale 1ns/1ps
module rtc_alarm_chk (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        osc_enable,
	input wire        missing_clock_detect_enable,
	input wire        alarm_irq,
	input wire        alarm_wake,
	input wire        alarm_reset
);
	// ********************************
	// Properties
	// ********************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_irq_one_cycle: assert property (alarm_irq |=> !alarm_irq) else $error("irq pulse too long");
	a_wake_one_cycle: assert property (alarm_wake |=> !alarm_wake) else $error("wake pulse too long");
	a_rst_one_cycle: assert property (alarm_reset |=> !alarm_reset) else $error("reset pulse too long");
	a_ctl_reset_zero: assert property ($rose(aresetn) |-> !osc_enable && !missing_clock_detect_enable)
		else $error("control not cleared by reset");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	c_alarm: cover property (alarm_irq && alarm_wake && alarm_reset);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// *** rtc_alarm_timer_control_test.sv ***
/*
 * Self-checking bench for the alarm and control block over AXI4-Lite.
 * Assumes the register map header and the checker file are compiled first.
 */
`timescale 1ns/1ps
`include "rtc_alarm_regs.vh"
module rtc_alarm_timer_control_test;
	reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg         s_axi_arvalid, s_axi_rready, mclk_timeout, seen;
	reg  [7:0]  s_axi_awaddr, s_axi_araddr;
	reg  [31:0] s_axi_wdata, d;
	reg  [3:0]  s_axi_wstrb;
	reg  [1:0]  r;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        osc_enable, missing_clock_detect_enable, alarm_irq, alarm_wake, alarm_reset;
	integer     error_cnt, samples_checked, cyc, n;

	rtc_alarm_timer_control i_dut (.*);

	// ********************************
	// Clock, timeout and tasks
	// ********************************
	// Clock of 4 ns period
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Cut a hang short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt = error_cnt + 1;
			report_and_stop;
		end
	end
	task report_and_stop;
		begin
			$display("errors %0d of %0d checks", error_cnt, samples_checked);
			if (error_cnt == 0 && samples_checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e, input [63:0] nm);
		begin
			samples_checked = samples_checked + 1;
			if (s !== e) begin
				error_cnt = error_cnt + 1;
				$display("unexpected %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		reg ah, wh;
		begin
			ah = 1'b1;
			wh = 1'b1;
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			while (ah || wh) begin
				@(posedge aclk);
				if (ah && s_axi_awready === 1'b1) begin
					ah = 1'b0;
					s_axi_awvalid <= 1'b0;
				end
				if (wh && s_axi_wready === 1'b1) begin
					wh = 1'b0;
					s_axi_wvalid <= 1'b0;
				end
			end
			do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do @(posedge aclk); while (s_axi_arready !== 1'b1);
			s_axi_arvalid <= 1'b0;
			do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
			d = s_axi_rdata;
			r = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
	// Write a self-clearing control bit and poll until it drops
	task handshake(input [31:0] v);
		begin
			wr(`RTC_CONTROL_OFS, v);
			do rd(`RTC_CONTROL_OFS); while (d[1:0] !== 2'h0);
		end
	endtask
	task wait_irq;
		begin
			n = 0;
			do begin
				@(posedge aclk);
				n = n + 1;
			end while (alarm_irq !== 1'b1);
		end
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, mclk_timeout} = 7'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		{error_cnt, samples_checked, cyc} = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`RTC_CONTROL_OFS);
		chk(d, 32'h0, "ctl_rst");
		rd(8'h40);
		chk(d, 32'h0, "unmapped");
		chk({30'h0, r}, {30'h0, `AXI_SLVERR}, "unm_resp");
		wr(`RTC_CONTROL_OFS, 32'hc0);
		chk({osc_enable, missing_clock_detect_enable}, 2'h3, "osc_mcd");
		mclk_timeout <= 1'b1;
		@(posedge aclk);
		mclk_timeout <= 1'b0;
		rd(`RTC_CONTROL_OFS);
		chk(d, 32'he0, "fail_set");
		wr(`RTC_CONTROL_OFS, 32'hc0);
		rd(`RTC_CONTROL_OFS);
		chk(d, 32'hc0, "fail_clr");
		// Stopped timer: set, wait, capture
		wr(`RTC_SNAPSHOT_OFS, 32'hfffffffd);
		handshake(32'hc2);
		wr(`RTC_SNAPSHOT_OFS, 32'h0);
		repeat (10) @(posedge aclk);
		handshake(32'hc1);
		rd(`RTC_SNAPSHOT_OFS);
		chk(d, 32'hfffffffd, "snapshot");
		// Free run across the wrap to a match at 2
		wr(`RTC_ROUTE_OFS, 32'h7);
		wr(`RTC_ALARM_OFS, 32'h2);
		wr(`RTC_CONTROL_OFS, 32'hd8);
		wait_irq;
		chk({alarm_wake, alarm_reset}, 2'h3, "routes");
		// Next match by unsigned addition of the interval; a miss ends in the timeout
		wr(`RTC_ALARM_OFS, 32'h2 + 32'h6);
		wait_irq;
		chk({alarm_wake, alarm_reset}, 2'h3, "routes2");
		// Auto-reset period of match value plus one, interval set once
		wr(`RTC_CONTROL_OFS, 32'hc0);
		wr(`RTC_ALARM_OFS, 32'h4);
		wr(`RTC_SNAPSHOT_OFS, 32'h0);
		handshake(32'hc2);
		wr(`RTC_CONTROL_OFS, 32'hcc);
		wr(`RTC_CONTROL_OFS, 32'hdc);
		wait_irq;
		wait_irq;
		chk(n, 5, "period");
		// Alarm disabled: no events, flag reads clear
		wr(`RTC_CONTROL_OFS, 32'hd4);
		seen = 1'b0;
		repeat (20) begin
			@(posedge aclk);
			if (alarm_irq !== 1'b0)
				seen = 1'b1;
		end
		chk(seen, 1'b0, "no_alarm");
		rd(`RTC_CONTROL_OFS);
		chk(d, 32'hd0, "ctl_flag");
		report_and_stop;
	end
endmodule
bind rtc_alarm_timer_control rtc_alarm_chk i_chk (.*);
